// ==== rtl/irq_mask_pkg.sv ====
package irq_mask_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_SET_OFFS   = 8'h88;
    localparam logic [7:0] MASK_CLR_OFFS   = 8'h8C;
    localparam logic [7:0] TXEV_SET_OFFS   = 8'h90;
    localparam logic [7:0] TXEV_CLR_OFFS   = 8'h94;
    localparam logic [7:0] TXMSK_SET_OFFS  = 8'h98;
    localparam logic [7:0] TXMSK_CLR_OFFS  = 8'h9C;
    localparam logic [7:0] EVENT_RD_OFFS   = 8'h80;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int          GLOBAL_IRQ_GATE_BIT   = 31;
    localparam int          ISO_TRANSMIT_SUM_BIT  = 6;
    localparam int          ISO_RECEIVE_SUM_BIT   = 7;
    localparam int          TX_CONTEXTS           = 8;
    localparam logic [31:0] MASK_WRITABLE         = 32'h81FF_83FF;
    localparam logic [31:0] MASK_RESET            = 32'h0000_0000;
    localparam logic [7:0]  TXEV_RESET            = 8'h00;
    localparam logic [7:0]  TXMSK_RESET           = 8'h00;
    localparam logic [31:0] UNMAPPED_READ         = 32'h0000_0000;
endpackage : irq_mask_pkg

// ==== rtl/edge_rise_detect.sv ====
`timescale 1ns/1ps
module edge_rise_detect #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_mclk,
    input  wire logic             i_nrst,
    input  wire logic [WIDTH-1:0] i_level,
    output logic      [WIDTH-1:0] o_rise
);
    logic [WIDTH-1:0] prev;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            prev <= '0;
        end else begin
            prev <= i_level;
        end
    end

    assign o_rise = i_level & ~prev;
endmodule : edge_rise_detect

// ==== rtl/wb_slave_decode.sv ====
`timescale 1ns/1ps
module wb_slave_decode (
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic        i_cyc,
    input  wire logic        i_stb,
    input  wire logic        i_we,
    input  wire logic [3:0]  i_sel,
    output logic             o_wr_pulse,
    output logic             o_rd_pulse,
    output logic [31:0]      o_lane_mask,
    output logic             o_ack
);
    // ------------------------------------------------------------
    // one-wait-state classic handshake
    // ------------------------------------------------------------
    logic ack;
    wire  req = i_cyc & i_stb & ~ack;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ack <= 1'b0;
        end else begin
            ack <= req;
        end
    end

    assign o_ack       = ack;
    assign o_wr_pulse  = req & i_we;
    assign o_rd_pulse  = req & ~i_we;
    assign o_lane_mask = {{8{i_sel[3]}}, {8{i_sel[2]}}, {8{i_sel[1]}}, {8{i_sel[0]}}};
endmodule : wb_slave_decode

// ==== rtl/host_irq_mask_iso_tx.sv ====
`timescale 1ns/1ps
module host_irq_mask_iso_tx #(
    parameter int CONTEXTS = irq_mask_pkg::TX_CONTEXTS
) (
    input  wire logic                i_mclk,
    input  wire logic                i_nrst,
    input  wire logic                i_cyc,
    input  wire logic                i_stb,
    input  wire logic                i_we,
    input  wire logic [7:0]          i_adr,
    input  wire logic [3:0]          i_sel,
    input  wire logic [31:0]         i_dat,
    input  wire logic [31:0]         i_event,
    input  wire logic [CONTEXTS-1:0] i_ctx_last_done,
    input  wire logic [CONTEXTS-1:0] i_ctx_irq_bits_set,
    output logic      [31:0]         o_dat,
    output logic                     o_ack,
    output logic                     o_irq,
    output logic                     o_iso_transmit_summary
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic        wr_pulse;
    logic        rd_pulse;
    logic [31:0] lane;
    logic        ack;

    wb_slave_decode u_bus (
        .i_mclk      (i_mclk),
        .i_nrst      (i_nrst),
        .i_cyc       (i_cyc),
        .i_stb       (i_stb),
        .i_we        (i_we),
        .i_sel       (i_sel),
        .o_wr_pulse  (wr_pulse),
        .o_rd_pulse  (rd_pulse),
        .o_lane_mask (lane),
        .o_ack       (ack)
    );

    wire [31:0] wdat_ones = i_dat & lane;
    wire hit_mask_set  = (i_adr == irq_mask_pkg::MASK_SET_OFFS);
    wire hit_mask_clr  = (i_adr == irq_mask_pkg::MASK_CLR_OFFS);
    wire hit_txev_set  = (i_adr == irq_mask_pkg::TXEV_SET_OFFS);
    wire hit_txev_clr  = (i_adr == irq_mask_pkg::TXEV_CLR_OFFS);
    wire hit_txmsk_set = (i_adr == irq_mask_pkg::TXMSK_SET_OFFS);
    wire hit_txmsk_clr = (i_adr == irq_mask_pkg::TXMSK_CLR_OFFS);
    wire hit_event     = (i_adr == irq_mask_pkg::EVENT_RD_OFFS);

    // ------------------------------------------------------------
    // interrupt enable mask
    // ------------------------------------------------------------
    logic [31:0] mask;
    wire  [31:0] mask_set_bits = (wr_pulse & hit_mask_set) ? wdat_ones : 32'h0000_0000;
    wire  [31:0] mask_clr_bits = (wr_pulse & hit_mask_clr) ? wdat_ones : 32'h0000_0000;
    // reserved positions never store, so they read zero
    wire  [31:0] next_mask = ((mask & ~mask_clr_bits) | mask_set_bits)
                             & irq_mask_pkg::MASK_WRITABLE;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            mask <= irq_mask_pkg::MASK_RESET;
        end else begin
            mask <= next_mask;
        end
    end

    // ------------------------------------------------------------
    // per-context transmit mask
    // ------------------------------------------------------------
    logic [CONTEXTS-1:0] tx_mask;
    wire  [CONTEXTS-1:0] txm_set = (wr_pulse & hit_txmsk_set) ? wdat_ones[CONTEXTS-1:0] : '0;
    wire  [CONTEXTS-1:0] txm_clr = (wr_pulse & hit_txmsk_clr) ? wdat_ones[CONTEXTS-1:0] : '0;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_mask <= '0;
        end else begin
            tx_mask <= (tx_mask & ~txm_clr) | txm_set;
        end
    end

    // ------------------------------------------------------------
    // transmit context event bits
    // ------------------------------------------------------------
    wire [CONTEXTS-1:0] ctx_irq = i_ctx_last_done & i_ctx_irq_bits_set;
    logic [CONTEXTS-1:0] ctx_rise;

    edge_rise_detect #(
        .WIDTH (CONTEXTS)
    ) u_edge (
        .i_mclk  (i_mclk),
        .i_nrst  (i_nrst),
        .i_level (ctx_irq),
        .o_rise  (ctx_rise)
    );

    logic [CONTEXTS-1:0] tx_context_event_bit;
    wire  [CONTEXTS-1:0] txe_set = (wr_pulse & hit_txev_set) ? wdat_ones[CONTEXTS-1:0] : '0;
    wire  [CONTEXTS-1:0] txe_clr = (wr_pulse & hit_txev_clr) ? wdat_ones[CONTEXTS-1:0] : '0;
    logic [CONTEXTS-1:0] next_txev;

    genvar g;
    generate
        for (g = 0; g < CONTEXTS; g++) begin : g_ctx
            // set wins over a same-cycle clear
            assign next_txev[g] = ctx_rise[g] | txe_set[g]
                                  | (tx_context_event_bit[g] & ~txe_clr[g]);
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_context_event_bit <= '0;
        end else begin
            tx_context_event_bit <= next_txev;
        end
    end

    // ------------------------------------------------------------
    // summary and interrupt output
    // ------------------------------------------------------------
    wire         iso_transmit_summary = |(tx_context_event_bit & tx_mask);
    logic [31:0] event_view;

    always_comb begin
        event_view = i_event;
        event_view[irq_mask_pkg::ISO_TRANSMIT_SUM_BIT] = iso_transmit_summary;
    end

    // each enable is a per-bit and of mask and event
    wire [30:0] gated   = event_view[30:0] & mask[30:0];
    wire        next_irq = mask[irq_mask_pkg::GLOBAL_IRQ_GATE_BIT] & (|gated);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    wire [31:0] txev_word  = {{(32-CONTEXTS){1'b0}}, tx_context_event_bit};
    wire [31:0] txclr_word = {{(32-CONTEXTS){1'b0}}, tx_context_event_bit & tx_mask};
    wire [31:0] txm_word   = {{(32-CONTEXTS){1'b0}}, tx_mask};
    wire [31:0] rd_word;

    assign rd_word = (hit_mask_set | hit_mask_clr)  ? mask :
                     hit_txev_set                   ? txev_word :
                     hit_txev_clr                   ? txclr_word :
                     (hit_txmsk_set | hit_txmsk_clr) ? txm_word :
                     hit_event                      ? event_view :
                     irq_mask_pkg::UNMAPPED_READ;

    logic [31:0] rdata;
    logic        irq;
    logic        summary;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata   <= 32'h0000_0000;
            irq     <= 1'b0;
            summary <= 1'b0;
        end else begin
            rdata   <= rd_pulse ? rd_word : 32'h0000_0000;
            irq     <= next_irq;
            summary <= iso_transmit_summary;
        end
    end

    assign o_dat                  = rdata;
    assign o_ack                  = ack;
    assign o_irq                  = irq;
    assign o_iso_transmit_summary = summary;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    chk_gate_blocks_irq: assert property (
        !mask[31] |=> !o_irq) else $error("irq raised with global gate off");
    chk_irq_from_pair: assert property (
        (mask[31] && |(event_view[30:0] & mask[30:0])) |=> o_irq)
        else $error("enabled event gave no irq");
    chk_irq_needs_pair: assert property (
        (mask[31] && !(|(event_view[30:0] & mask[30:0]))) |=> !o_irq)
        else $error("irq without enabled event");
    chk_mask_rsvd_zero: assert property (
        mask[14:10] == 5'h00) else $error("reserved mask bits stored");
    chk_rise_sets_bit: assert property (
        $rose(ctx_irq[3]) |=> tx_context_event_bit[3]) else $error("edge did not set bit");
    chk_hold_no_clear: assert property (
        (tx_context_event_bit[0] && !(wr_pulse && hit_txev_clr && wdat_ones[0]))
        |=> tx_context_event_bit[0]) else $error("event bit lost without clear");
    chk_sw_set_bit: assert property (
        (wr_pulse && hit_txev_set && wdat_ones[1]) |=> tx_context_event_bit[1])
        else $error("set write ignored");
    chk_clr_readback: assert property (
        (rd_pulse && hit_txev_clr) |=> o_dat == {24'h000000, $past(tx_context_event_bit & tx_mask)})
        else $error("clear-address read wrong");
    chk_mask_readback: assert property (
        (rd_pulse && (hit_mask_set || hit_mask_clr)) |=> o_dat == $past(mask))
        else $error("mask read wrong");
    chk_summary_or: assert property (
        o_iso_transmit_summary == $past(|(tx_context_event_bit & tx_mask)))
        else $error("summary mismatch");

    cov_irq_raised:  cover property (mask[31] ##1 o_irq);
    cov_ctx_edge:    cover property ($rose(ctx_irq[7]));
    cov_set_vs_clr:  cover property (ctx_rise[0] && wr_pulse && hit_txev_clr);
endmodule : host_irq_mask_iso_tx

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [7:0] MSET = irq_mask_pkg::MASK_SET_OFFS;
    localparam logic [7:0] MCLR = irq_mask_pkg::MASK_CLR_OFFS;
    localparam logic [7:0] TSET = irq_mask_pkg::TXEV_SET_OFFS;
    localparam logic [7:0] TCLR = irq_mask_pkg::TXEV_CLR_OFFS;
    localparam logic [7:0] KSET = irq_mask_pkg::TXMSK_SET_OFFS;
    logic        i_mclk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_cyc = 1'b0;
    logic        i_stb = 1'b0;
    logic        i_we = 1'b0;
    logic [7:0]  i_adr = 8'h00;
    logic [3:0]  i_sel = 4'hF;
    logic [31:0] i_dat = 32'h0000_0000;
    logic [31:0] i_event = 32'h0000_0000;
    logic [7:0]  i_ctx_last_done = 8'h00;
    logic [7:0]  i_ctx_irq_bits_set = 8'h00;
    logic [31:0] o_dat;
    logic        o_ack;
    logic        o_irq;
    logic        o_iso_transmit_summary;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cyc_cnt = 0;
    int          bits[9] = '{24, 20, 19, 15, 9, 8, 7, 5, 0};

    host_irq_mask_iso_tx dut (
        .i_mclk                 (i_mclk),
        .i_nrst                 (i_nrst),
        .i_cyc                  (i_cyc),
        .i_stb                  (i_stb),
        .i_we                   (i_we),
        .i_adr                  (i_adr),
        .i_sel                  (i_sel),
        .i_dat                  (i_dat),
        .i_event                (i_event),
        .i_ctx_last_done        (i_ctx_last_done),
        .i_ctx_irq_bits_set     (i_ctx_irq_bits_set),
        .o_dat                  (o_dat),
        .o_ack                  (o_ack),
        .o_irq                  (o_irq),
        .o_iso_transmit_summary (o_iso_transmit_summary)
    );

    always #12.5 i_mclk = ~i_mclk;

    // ------------------------------------------------------------
    // bus tasks and run control
    // ------------------------------------------------------------
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
        @(posedge i_mclk);
        i_cyc <= 1'b1;
        i_stb <= 1'b1;
        i_we  <= we;
        i_adr <= adr;
        i_dat <= wd;
        do @(posedge i_mclk); while (o_ack !== 1'b1);
        rd = o_dat;
        i_cyc <= 1'b0;
        i_stb <= 1'b0;
        i_we  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] v;
        wb(1'b1, adr, wd, v);
    endtask : wr

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] v;
        wb(1'b0, adr, 32'h0000_0000, v);
        `CHK(v, exp)
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : tick

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    // hang guard
    always @(posedge i_mclk) begin
        cyc_cnt++;
        if (cyc_cnt == 4000) begin
            error_cnt++;
            $display("MISMATCH t=%0t run timed out", $time);
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge i_mclk);
        i_nrst <= 1'b1;
        rd(MSET, 32'h0000_0000);
        rd(TSET, 32'h0000_0000);
        wr(MSET, 32'hFFFF_FFFF);
        rd(MSET, irq_mask_pkg::MASK_WRITABLE);
        rd(MCLR, irq_mask_pkg::MASK_WRITABLE);
        wr(MCLR, 32'h0000_FFFF);
        rd(MSET, irq_mask_pkg::MASK_WRITABLE & 32'hFFFF_0000);
        wr(MCLR, 32'hFFFF_FFFF);
        $display("test mask access done");
        foreach (bits[i]) begin
            @(posedge i_mclk);
            i_event <= 32'h1 << bits[i];
            wr(MSET, 32'h8000_0000 | (32'h1 << bits[i]));
            tick(2);
            `CHK(o_irq, 1'b1)
            @(posedge i_mclk);
            i_event <= 32'h0000_0000;
            tick(3);
            `CHK(o_irq, 1'b0)
            wr(MCLR, 32'h8000_0000 | (32'h1 << bits[i]));
        end
        @(posedge i_mclk);
        i_event <= 32'hFFFF_FFBF;
        wr(MSET, 32'h01FF_83BF);
        tick(2);
        `CHK(o_irq, 1'b0)
        wr(MSET, 32'h8000_0000);
        tick(2);
        `CHK(o_irq, 1'b1)
        wr(MCLR, 32'h7FFF_FFFF);
        wr(MSET, 32'h0000_7C00);
        tick(2);
        `CHK(o_irq, 1'b0)
        $display("test event gating done");
        wr(TSET, 32'hFFFF_FFFF);
        rd(TSET, 32'h0000_00FF);
        rd(TCLR, 32'h0000_0000);
        wr(KSET, 32'h0000_000F);
        rd(TCLR, 32'h0000_000F);
        tick(2);
        `CHK(o_iso_transmit_summary, 1'b1)
        rd(irq_mask_pkg::EVENT_RD_OFFS, 32'hFFFF_FFFF);
        wr(TCLR, 32'h0000_0005);
        rd(TSET, 32'h0000_00FA);
        wr(TCLR, 32'h0000_0000);
        wr(TSET, 32'h0000_0000);
        rd(TSET, 32'h0000_00FA);
        wr(TCLR, 32'h0000_00FF);
        tick(2);
        `CHK(o_iso_transmit_summary, 1'b0)
        $display("test tx event access done");
        @(posedge i_mclk);
        i_event <= 32'h0000_0000;
        i_ctx_irq_bits_set <= 8'hF7;
        i_ctx_last_done <= 8'h08;
        tick(3);
        rd(TSET, 32'h0000_0000);
        @(posedge i_mclk);
        i_ctx_last_done <= 8'h00;
        @(posedge i_mclk);
        i_ctx_irq_bits_set <= 8'hFF;
        i_ctx_last_done <= 8'h08;
        tick(3);
        rd(TSET, 32'h0000_0008);
        wr(MSET, 32'h8000_0040);
        tick(2);
        `CHK(o_irq, 1'b1)
        wr(TCLR, 32'h0000_0008);
        tick(3);
        rd(TSET, 32'h0000_0000);
        `CHK(o_irq, 1'b0)
        $display("test context events done");
        stop_test();
    end
endmodule : testbench
